// ---- common/load_consts.svh ----
`ifndef LOAD_CONSTS_SVH
`define LOAD_CONSTS_SVH

`define CLK_PERIOD_NS     10
`define CLEAR_TIME_NS     1000
`define CLEAR_CYCLES      ((`CLEAR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_HALF_NS      320
`define SLOW_HALF_CYCLES  (`SLOW_HALF_NS / `CLK_PERIOD_NS)
`define FAST_FACTOR       8
`define FAST_HALF_CYCLES  (`SLOW_HALF_CYCLES / `FAST_FACTOR)
`define FAST_START_BITS   16

`define MODE_CODE_SLAVE   3'h7
`define MODE_CODE_SMASTER 3'h0
`define MODE_CODE_PUP     3'h4
`define MODE_CODE_PDOWN   3'h6

`define ADDR_UP_START     22'h000000
`define ADDR_DOWN_START   22'h03ffff

`define OFF_CTRL          32'h00000000
`define OFF_STATUS        32'h00000004
`define OFF_ADDR          32'h00000008
`define OFF_BITS          32'h0000000c

`define CTRL_FAST_BIT     0
`define CTRL_WIDTH_BIT    1
`define CTRL_LV_BIT       2
`define CTRL_FINISH_BIT   3
`define CTRL_RESET        4'h0

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- common/load_pkg.sv ----
package load_pkg;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'h0,
    ST_WAIT  = 3'h1,
    ST_LOAD  = 3'h3,
    ST_DONE  = 3'h2,
    ST_IDLE  = 3'h6
  } state_t;

  typedef enum logic [2:0] {
    MODE_SLAVE      = 3'h0,
    MODE_SER_MASTER = 3'h1,
    MODE_PAR_UP     = 3'h2,
    MODE_PAR_DOWN   = 3'h3,
    MODE_NONE       = 3'h4
  } mode_t;

  typedef struct packed {
    logic [7:0] boot_data;
    logic [2:0] mode_pins;
    logic       init;
    logic       data;
    logic       clk;
  } pins_t;

  typedef struct packed {
    logic valid;
    logic value;
  } cfg_bit_t;

endpackage

// ---- verilog/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 14
) (
  input  logic         aclk,
  input  logic         aresetn,
  input  logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic         rise,
  output logic         fall
);
  // pins preset high, bit 0 low like an idle clock, so no false edge
  localparam logic [W-1:0] PRESET = {{(W-1){1'b1}}, 1'b0};

  logic [W-1:0] stage1_reg;
  logic         prev_reg;

  // two flops, bit 0 also edge detected from the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= PRESET;
      q          <= PRESET;
      prev_reg   <= 1'b0;
    end else begin
      stage1_reg <= d;
      q          <= stage1_reg;
      prev_reg   <= q[0];
    end
  end

  assign rise = q[0] & ~prev_reg;
  assign fall = ~q[0] & prev_reg;
endmodule

// ---- verilog/bitstream_load_front_end.sv ----
`timescale 1ns/100ps
`include "load_consts.svh"
module bitstream_load_front_end (
  input  logic               aclk,
  input  logic               aresetn,
  input  logic [31:0]        awaddr,
  input  logic               awvalid,
  output logic               awready,
  input  logic [31:0]        wdata,
  input  logic [3:0]         wstrb,
  input  logic               wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  logic               bready,
  input  logic [31:0]        araddr,
  input  logic               arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  logic               rready,
  input  logic               mode_sel_bit0,
  input  logic               mode_sel_bit1,
  input  logic               mode_sel_bit2,
  input  logic               config_clock_in,
  output logic               config_clock_out,
  output logic               config_clock_oe,
  input  logic               data_in,
  output logic               daisy_out,
  input  logic               init_in,
  output logic               init_out,
  output logic               init_oe,
  output logic               low_while_loading,
  output logic               high_while_loading,
  output logic [21:0]        boot_addr,
  output logic               boot_addr_oe,
  output logic               upper_addr_oe,
  input  logic [7:0]         boot_data,
  output logic               read_clock,
  input  logic               bits_consumed,
  output load_pkg::cfg_bit_t cfg_stream
);
  import load_pkg::*;

  localparam logic [7:0]  CLEAR_LAST = 8'(`CLEAR_CYCLES - 1);
  localparam logic [5:0]  SLOW_HALF  = 6'(`SLOW_HALF_CYCLES);
  localparam logic [5:0]  FAST_HALF  = 6'(`FAST_HALF_CYCLES);
  localparam logic [31:0] FAST_START = 32'(`FAST_START_BITS);

  function automatic mode_t decode_mode(input logic [2:0] pins);
    case (pins)
      `MODE_CODE_SLAVE:   decode_mode = MODE_SLAVE;
      `MODE_CODE_SMASTER: decode_mode = MODE_SER_MASTER;
      `MODE_CODE_PUP:     decode_mode = MODE_PAR_UP;
      `MODE_CODE_PDOWN:   decode_mode = MODE_PAR_DOWN;
      default:            decode_mode = MODE_NONE;
    endcase
  endfunction

  function automatic logic is_parallel(input mode_t m);
    return (m == MODE_PAR_UP) || (m == MODE_PAR_DOWN);
  endfunction

  function automatic logic is_master(input mode_t m);
    return (m == MODE_SER_MASTER) || is_parallel(m);
  endfunction

  function automatic logic forward(input logic b, input logic consumed);
    return consumed ? 1'b1 : b;
  endfunction

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  pins_t      pins_raw;
  pins_t      pins_s;
  logic       clk_rise_s;
  logic       clk_fall_s;
  state_t     st_reg;
  mode_t      mode_reg;
  logic [7:0] clear_cnt_reg;
  logic [3:0] ctrl_reg;
  logic       running;
  logic       master;
  logic       par;
  logic       fast_act;
  logic [5:0] half;
  logic [5:0] div_cnt_reg;
  logic       config_clock_int_reg;
  logic       tick;
  logic       rise_ev;
  logic       fall_ev;
  logic [2:0] byte_cnt_reg;
  logic       started_reg;
  logic       latch_ev;
  logic [21:0] addr_reg;
  logic       bit_reg;
  logic       stage_reg;
  logic       primed_reg;
  logic [7:0] hold_reg;
  logic [7:0] shift_reg;
  logic       pload_reg;
  logic       live_reg;
  logic [31:0] bit_cnt_reg;

  assign pins_raw = {boot_data, mode_sel_bit2, mode_sel_bit1, mode_sel_bit0,
                     init_in, data_in, config_clock_in};

  pin_sync #(.W($bits(pins_t))) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_s),
    .rise    (clk_rise_s),
    .fall    (clk_fall_s)
  );

  // sequencing: clear, wait for init, then load and done, or idle for an unsupported mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= ST_CLEAR;
      mode_reg <= MODE_NONE;
    end else begin
      case (st_reg)
        ST_CLEAR: begin
          if (clear_cnt_reg == CLEAR_LAST) begin
            st_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pins_s.init) begin
            mode_reg <= decode_mode(pins_s.mode_pins);
            st_reg   <= (decode_mode(pins_s.mode_pins) == MODE_NONE) ? ST_IDLE : ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (ctrl_reg[`CTRL_FINISH_BIT]) begin
            st_reg <= ST_DONE;
          end
        end
        ST_DONE: st_reg <= ST_DONE;
        ST_IDLE: st_reg <= ST_IDLE;
        default: st_reg <= ST_CLEAR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st_reg != ST_CLEAR) begin
      clear_cnt_reg <= 8'h00;
    end else begin
      clear_cnt_reg <= clear_cnt_reg + 8'h01;
    end
  end

  // init held low by this device only while clearing
  assign init_out = 1'b0;
  assign init_oe  = (st_reg == ST_CLEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_while_loading  <= 1'b0;
      high_while_loading <= 1'b1;
    end else begin
      low_while_loading  <= (st_reg == ST_DONE);
      high_while_loading <= (st_reg != ST_DONE);
    end
  end

  assign running  = (st_reg == ST_LOAD);
  assign master   = running && is_master(mode_reg);
  assign par      = running && is_parallel(mode_reg);
  assign fast_act = ctrl_reg[`CTRL_FAST_BIT] && (bit_cnt_reg >= FAST_START);
  assign half     = fast_act ? FAST_HALF : SLOW_HALF;
  assign tick     = master && (div_cnt_reg >= half - 6'h01);

  // clock divider for master modes
  always_ff @(posedge aclk) begin
    if (!aresetn || !master) begin
      div_cnt_reg  <= 6'h00;
      config_clock_int_reg <= 1'b0;
    end else if (tick) begin
      div_cnt_reg  <= 6'h00;
      config_clock_int_reg <= ~config_clock_int_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  assign rise_ev = running && ((mode_reg == MODE_SLAVE) ? clk_rise_s : (tick && !config_clock_int_reg));
  assign fall_ev = running && ((mode_reg == MODE_SLAVE) ? clk_fall_s : (tick && config_clock_int_reg));

  // config clock pin, held low in parallel modes until first latch
  always_ff @(posedge aclk) begin
    if (!aresetn || !master) begin
      config_clock_out <= 1'b0;
      config_clock_oe  <= 1'b0;
    end else begin
      config_clock_oe <= 1'b1;
      if (tick) begin
        config_clock_out <= ~config_clock_int_reg && (!par || started_reg || latch_ev);
      end
    end
  end

  // byte timing for parallel modes
  assign latch_ev   = rise_ev && par && (byte_cnt_reg == 3'h7);
  assign read_clock = par && (byte_cnt_reg == 3'h7);

  always_ff @(posedge aclk) begin
    if (!aresetn || !par) begin
      byte_cnt_reg <= 3'h7;
      started_reg  <= 1'b0;
    end else if (rise_ev) begin
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
      if (latch_ev) begin
        started_reg <= 1'b1;
      end
    end
  end

  // boot memory address, one counter for all 22 lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= `ADDR_UP_START;
    end else if (st_reg == ST_WAIT) begin
      addr_reg <= (decode_mode(pins_s.mode_pins) == MODE_PAR_DOWN) ?
                  `ADDR_DOWN_START : `ADDR_UP_START;
    end else if (latch_ev) begin
      addr_reg <= (mode_reg == MODE_PAR_DOWN) ? addr_reg - 22'h000001 :
                  addr_reg + 22'h000001;
    end
  end

  assign boot_addr     = addr_reg;
  assign boot_addr_oe  = par;
  assign upper_addr_oe = par && (ctrl_reg[`CTRL_WIDTH_BIT] || ctrl_reg[`CTRL_LV_BIT]);

  // serial data path and daisy chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_reg    <= 1'b0;
      stage_reg  <= 1'b1;
      primed_reg <= 1'b0;
      hold_reg   <= 8'h00;
      shift_reg  <= 8'hff;
      pload_reg  <= 1'b0;
      live_reg   <= 1'b0;
      daisy_out  <= 1'b1;
      cfg_stream <= '0;
    end else begin
      cfg_stream.valid <= 1'b0;
      if (!running) begin
        primed_reg <= 1'b0;
        pload_reg  <= 1'b0;
        live_reg   <= 1'b0;
      end else begin
        if (rise_ev) begin
          case (mode_reg)
            MODE_SLAVE: begin
              bit_reg    <= pins_s.data;
              cfg_stream <= '{valid: 1'b1, value: pins_s.data};
            end
            MODE_SER_MASTER: begin
              primed_reg <= 1'b1;
              if (primed_reg) begin
                bit_reg    <= pins_s.data;
                cfg_stream <= '{valid: 1'b1, value: pins_s.data};
              end
            end
            default: begin
              if (latch_ev) begin
                hold_reg  <= pins_s.boot_data;
                pload_reg <= 1'b1;
              end
            end
          endcase
        end
        if (fall_ev) begin
          case (mode_reg)
            MODE_SLAVE: begin
              daisy_out <= forward(bit_reg, bits_consumed);
            end
            MODE_SER_MASTER: begin
              daisy_out <= forward(stage_reg, bits_consumed);
              stage_reg <= bit_reg;
            end
            default: begin
              if (live_reg) begin
                daisy_out  <= forward(shift_reg[0], bits_consumed);
                cfg_stream <= '{valid: 1'b1, value: shift_reg[0]};
              end
              shift_reg <= pload_reg ? hold_reg : {1'b1, shift_reg[7:1]};
              live_reg  <= live_reg | pload_reg;
              pload_reg <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_reg <= 32'h00000000;
    end else if (cfg_stream.valid) begin
      bit_cnt_reg <= bit_cnt_reg + 32'h00000001;
    end
  end

  // register bus slave
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_go;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign awready = !aw_hold_reg && !bvalid;
  assign wready  = !w_hold_reg && !bvalid;
  assign arready = !rvalid;
  assign wr_go   = aw_hold_reg && w_hold_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 32'h00000000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= (awaddr_reg == `OFF_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_go && awaddr_reg == `OFF_CTRL && wstrb_reg[0]) begin
      ctrl_reg <= wdata_reg[3:0];
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (araddr)
      `OFF_CTRL:   rd_word = {28'h0000000, ctrl_reg};
      `OFF_STATUS: rd_word = {16'h0000, shift_reg, fast_act, pins_s.init,
                              st_reg, mode_reg};
      `OFF_ADDR:   rd_word = {10'h000, addr_reg};
      `OFF_BITS:   rd_word = bit_cnt_reg;
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks
  chk_slave_sample: assert property (
    (rise_ev && mode_reg == MODE_SLAVE) |=>
      (cfg_stream.valid && cfg_stream.value == $past(pins_s.data)))
    else $error("slave bit not sampled on clock rise");

  chk_slave_daisy: assert property (
    (fall_ev && mode_reg == MODE_SLAVE && !bits_consumed) |=>
      (daisy_out == $past(bit_reg)))
    else $error("slave daisy output not updated on fall");

  chk_mode_decode: assert property (
    (st_reg == ST_WAIT && pins_s.init && pins_s.mode_pins == 3'h7) |=>
      (mode_reg == MODE_SLAVE && st_reg == ST_LOAD))
    else $error("mode pins 111 did not select slave");

  chk_master_pipe: assert property (
    (fall_ev && mode_reg == MODE_SER_MASTER && !bits_consumed) |=>
      (daisy_out == $past(stage_reg) && stage_reg == $past(bit_reg)))
    else $error("serial master daisy pipeline wrong");

  chk_fast_rate: assert property (
    (tick && fast_act) |=> (!tick)[*3] ##1 (tick || !fast_act || !master))
    else $error("fast clock half period not four cycles");

  chk_done_pins: assert property (
    (st_reg == ST_DONE) |=> (low_while_loading && !high_while_loading))
    else $error("low while loading not high after done");

  chk_addr_step: assert property (
    (latch_ev && mode_reg == MODE_PAR_UP) |=> (boot_addr == $past(boot_addr) + 22'h000001))
    else $error("ascending address did not step by one");

  chk_byte_load: assert property (
    (fall_ev && pload_reg) |=> (shift_reg == $past(hold_reg) && live_reg))
    else $error("latched byte not loaded into shifter");

  chk_upper_lines: assert property (
    (par && !ctrl_reg[`CTRL_WIDTH_BIT] && !ctrl_reg[`CTRL_LV_BIT]) |-> !upper_addr_oe)
    else $error("upper address lines driven without request");

  chk_idle_quiet: assert property (
    (mode_reg == MODE_NONE) |-> (!config_clock_oe && !read_clock && daisy_out))
    else $error("activity in an unsupported mode");

  chk_init_wait: assert property (
    (st_reg == ST_WAIT && !pins_s.init) |=> (st_reg == ST_WAIT && !init_oe))
    else $error("load began before init went high");
endmodule

// ---- tb/boot_memory_model.sv ----
`timescale 1ns/100ps
module boot_memory_model (
  input  wire logic        slave_run,
  input  wire logic        serial_master,
  input  wire logic        config_clock_out,
  input  wire logic        low_while_loading,
  input  wire logic [21:0] boot_addr,
  input  wire logic        boot_addr_oe,
  input  wire logic        init_level,
  output logic             source_clock,
  output logic             data_in,
  output logic [7:0]       boot_data
);
  int   sidx  = 0;
  int   midx  = 0;
  logic frame = 1'b0;
  logic noise = 1'b0;
  function automatic logic pat(input int k);
    return k[0] ^ k[2] ^ k[3];
  endfunction
  initial source_clock = 1'b0;
  // released lines show a changing pattern
  always #10 noise = ~noise;
  // external clock source, clock only inside a frame
  always @(posedge slave_run) begin
    wait (init_level === 1'b1);
    frame = 1'b1;
    #37;
    repeat (12) begin
      source_clock = 1'b1;
      #80 source_clock = 1'b0;
      sidx++;
      #80;
    end
    frame = 1'b0;
  end
  // serial memory steps on each clock rise while enabled
  always @(posedge config_clock_out) if (!low_while_loading) midx <= midx + 1;
  assign data_in = frame ? pat(sidx) :
                   (serial_master && !low_while_loading) ? pat(midx) : noise;
  // byte memory content tied to its address
  assign boot_data = boot_addr_oe ? (boot_addr[7:0] ^ 8'ha5) : {8{noise}} ^ 8'h3c;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "load_consts.svh"
module testbench;
  import load_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mode_sel_bit0, mode_sel_bit1, mode_sel_bit2;
  logic        config_clock_in, config_clock_out, config_clock_oe, data_in, daisy_out;
  logic        init_in, init_out, init_oe, low_while_loading, high_while_loading;
  logic        boot_addr_oe, upper_addr_oe, read_clock, bits_consumed, init_ext;
  logic        slave_run, serial_master, source_clock;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [21:0] boot_addr;
  logic [7:0]  boot_data;
  cfg_bit_t    cfg_stream;
  int          errors, n_compared;
  logic        rd_seen [0:63];

  // open-drain init with pull-up, shared clock pin
  assign init_in = init_oe ? 1'b0 : init_ext;
  assign config_clock_in = config_clock_oe ? config_clock_out : source_clock;

  bitstream_load_front_end i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mode_sel_bit0(mode_sel_bit0), .mode_sel_bit1(mode_sel_bit1),
    .mode_sel_bit2(mode_sel_bit2), .config_clock_in(config_clock_in),
    .config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
    .data_in(data_in), .daisy_out(daisy_out), .init_in(init_in), .init_out(init_out),
    .init_oe(init_oe), .low_while_loading(low_while_loading),
    .high_while_loading(high_while_loading), .boot_addr(boot_addr),
    .boot_addr_oe(boot_addr_oe), .upper_addr_oe(upper_addr_oe), .boot_data(boot_data),
    .read_clock(read_clock), .bits_consumed(bits_consumed), .cfg_stream(cfg_stream));

  boot_memory_model i_memory (
    .slave_run(slave_run), .serial_master(serial_master),
    .config_clock_out(config_clock_out), .low_while_loading(low_while_loading),
    .boot_addr(boot_addr), .boot_addr_oe(boot_addr_oe), .init_level(init_in),
    .source_clock(source_clock), .data_in(data_in), .boot_data(boot_data));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic pat(input int k);
    return k[0] ^ k[2] ^ k[3];
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // reset, program control, hold init low a while, then release it
  task automatic start(input logic [2:0] code, input logic [31:0] ctrl, input mode_t m);
    logic [1:0]  r;
    logic [31:0] d;
    @(posedge aclk);
    {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= code;
    slave_run <= 1'b0;
    init_ext <= 1'b0;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_write(`OFF_CTRL, ctrl, r);
    check("ctrl write resp", r, `RESP_OKAY);
    repeat (50) @(posedge aclk);
    check("init pulled low in clear", init_oe, 1'b1);
    repeat (100) @(posedge aclk);
    check("no clock while init held", config_clock_oe, 1'b0);
    init_ext <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_read(`OFF_STATUS, d, r);
    check("mode field", d[2:0], m);
  endtask

  task automatic idle_test;
    logic [1:0]  r;
    logic [31:0] d;
    start(3'h3, 32'h0, MODE_NONE);
    repeat (200) @(posedge aclk);
    check("idle clock drive", config_clock_oe, 1'b0);
    check("idle address drive", boot_addr_oe, 1'b0);
    check("idle daisy", daisy_out, 1'b1);
    axi_read(32'h40, d, r);
    check("unmapped read resp", r, `RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_write(`OFF_STATUS, 32'hff, r);
    check("read only write resp", r, `RESP_SLVERR);
    axi_read(`OFF_CTRL, d, r);
    check("ctrl readback", d[3:0], `CTRL_RESET);
  endtask

  task automatic slave_test;
    logic [1:0]  r;
    logic [31:0] d;
    start(`MODE_CODE_SLAVE, 32'h0, MODE_SLAVE);
    slave_run <= 1'b1;
    for (int k = 1; k <= 12; k++) begin
      @(posedge config_clock_in);
      repeat (6) @(posedge aclk);
      if (k >= 2) check("daisy held to fall", daisy_out, (k > 10) ? 1'b1 : pat(k - 2));
      bits_consumed <= (k >= 10);
      @(negedge config_clock_in);
      repeat (6) @(posedge aclk);
      check("slave daisy bit", daisy_out, (k >= 10) ? 1'b1 : pat(k - 1));
    end
    bits_consumed <= 1'b0;
    axi_read(`OFF_BITS, d, r);
    check("slave bit count", d, 32'd12);
  endtask

  task automatic master_test;
    logic [1:0] r;
    time        t0;
    t0 = 0;
    serial_master <= 1'b1;
    start(`MODE_CODE_SMASTER, 32'h1 << `CTRL_FAST_BIT, MODE_SER_MASTER);
    for (int k = 1; k <= 40; k++) begin
      @(posedge config_clock_out);
      rd_seen[k] = data_in;
      if (k == 3) check("slow period", 32'($time - t0), 2 * `SLOW_HALF_CYCLES * 10);
      if (k == 40) check("fast period", 32'($time - t0), 2 * `FAST_HALF_CYCLES * 10);
      t0 = $time;
      @(negedge config_clock_out);
      repeat (2) @(posedge aclk);
      if (k >= 3) check("master daisy bit", daisy_out, rd_seen[k - 1]);
    end
    check("memory enabled in load", low_while_loading, 1'b0);
    axi_write(`OFF_CTRL, 32'h1 << `CTRL_FINISH_BIT, r);
    repeat (4) @(posedge aclk);
    check("low while loading after done", low_while_loading, 1'b1);
    check("high while loading after done", high_while_loading, 1'b0);
    serial_master <= 1'b0;
  endtask

  task automatic par_test(input logic [2:0] code, input mode_t m, input logic [21:0] a0,
                          input logic [31:0] ctrl, input logic up_oe, input int step);
    logic [15:0] s;
    logic [21:0] a1;
    start(code, ctrl, m);
    a1 = a0 + 22'(step);
    s = {a1[7:0] ^ 8'ha5, a0[7:0] ^ 8'ha5};
    check("upper address drive", upper_addr_oe, up_oe);
    wait (read_clock === 1'b1);
    check("clock idle before first byte", config_clock_out, 1'b0);
    check("first address", boot_addr, a0);
    check("address drive", boot_addr_oe, 1'b1);
    @(posedge config_clock_out);
    repeat (2) @(posedge aclk);
    check("stepped address", boot_addr, a1);
    for (int k = 1; k <= 17; k++) begin
      @(negedge config_clock_out);
      repeat (2) @(posedge aclk);
      if (k >= 2) check("parallel daisy bit", daisy_out, s[k - 2]);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bits_consumed} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} = 3'h7;
    {init_ext, slave_run, serial_master} = 3'b100;
    errors = 0;
    n_compared = 0;
    repeat (2) @(posedge aclk);
    idle_test;
    slave_test;
    master_test;
    par_test(`MODE_CODE_PUP, MODE_PAR_UP, `ADDR_UP_START, 32'h0, 1'b0, 1);
    par_test(`MODE_CODE_PUP, MODE_PAR_UP, `ADDR_UP_START, 32'h1 << `CTRL_WIDTH_BIT, 1'b1, 1);
    par_test(`MODE_CODE_PDOWN, MODE_PAR_DOWN, `ADDR_DOWN_START, 32'h1 << `CTRL_LV_BIT, 1'b1, -1);
    give_verdict;
  end

  initial begin
    #200000;
    errors++;
    give_verdict;
  end
endmodule
